/* File: ccd_divider.sv */
/*
 prescaler of the oscillator clock: cpu clock tick per selector and
 peripheral divider taps. assumes run is low whenever the oscillator is off.
*/
module ccd_divider
   import ccd_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       srst,
   // control
   input  wire logic       osc_on,
   input  wire logic       cpu_en,
   input  wire ccd_sel_t   sel,
   // outputs
   output logic            tick_q,
   output logic [3:0]      taps_q
);

   logic [3:0] taps_d;
   logic       tick_d;
   logic [3:0] mask;

   always_comb
   begin
      mask   = 4'((5'h01 << sel) - 5'h01);
      // taps are cleared while stopped so peripherals freeze
      taps_d = osc_on ? taps_q + 4'h1 : 4'h0; // RL10
      tick_d = osc_on & cpu_en & ((taps_q & mask) == mask); // RL2
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         taps_q <= 4'h0;
         tick_q <= 1'b0;
      end
      else
      begin
         taps_q <= taps_d;
         tick_q <= tick_d;
      end
   end

   a_slow_tick_gap : assert property (@(posedge clock) disable iff (srst)
      // a switchover away from sixteen may bring a faster tick inside the window
      (tick_q && sel == 3'h4 && $stable(sel)) |=> (!tick_q || sel != 3'h4) [*8]) // RL2
      else $error("divide by sixteen tick too soon");

endmodule

/* File: ccd_map.svh */
/*
 constants of the cpu clock divider control: register address, field layout,
 reset value and timing counts. assumes the including file needs only macros.
*/
// What this block does
// RL1 - reset loads the selector with 04, the slowest cpu clock, divide by sixteen
// RL2 - selector codes 000..100 give oscillator clock divided by 1, 2, 4, 8, 16
// RL3 - software writes zeros to bits three through seven of the register
// RL4 - the shortest instruction lasts two periods of the selected cpu clock
// RL5 - the stop instruction halts the system oscillator
// RL6 - while the reset pin is low, oscillation stays stopped
// RL7 - after reset release, wait 2^17 oscillator periods before the cpu runs slowest
// RL8 - old clock may persist up to 16, 8, 4, 2, 1 instructions per old setting
// RL9 - each such instruction unit is a minimum instruction at the old clock
// RL10 - peripheral clocks divide the system clock and stop with it
// RL11 - the register accepts single-bit and whole-byte writes
// RL12 - two standby modes: one stops the oscillator, one halts the cpu
// RL13 - software never executes stop while an external clock drives the oscillator
// RL14 - upper bits read zero; a prohibited selector write keeps the current selection
`ifndef CCD_MAP_SVH
`define CCD_MAP_SVH

`define CCD_SEL_ADDR      16'hfffb
`define CCD_SEL_RESET     8'h04
`define CCD_SEL_LSB       0
`define CCD_SEL_MSB       2
`define CCD_SEL_MAX       3'h4
`define CCD_INSTR_CLOCKS  2
`define CCD_UNITS_DIV1    5'h10
// stabilization time in oscillator periods; the oscillator clock is the block clock
`define CCD_STAB_OSC_PER  131072
`define CCD_CLK_PER_OSC   1
`define CCD_STAB_CYCLES   (`CCD_STAB_OSC_PER * `CCD_CLK_PER_OSC)

`endif

/* File: ccd_pkg.sv */
/*
 types and shared helpers of the cpu clock divider control.
 assumes ccd_map.svh is on the include path.
*/
`include "ccd_map.svh"

package ccd_pkg;

   typedef logic [2:0] ccd_sel_t;

   typedef enum logic [2:0] {
      ST_RESET,
      ST_STAB,
      ST_RUN,
      ST_HALT,
      ST_STOP
   } ccd_state_t;

   function automatic logic ccd_sel_legal(input ccd_sel_t sel);
      ccd_sel_legal = (sel <= `CCD_SEL_MAX);
   endfunction

   // instruction units the old clock may persist after a selector write
   function automatic logic [4:0] ccd_switch_units(input ccd_sel_t old_sel);
      ccd_switch_units = 5'(`CCD_UNITS_DIV1 >> old_sel);
   endfunction

endpackage

/* File: ccd_stab_timer.sv */
/*
 oscillation stabilization timer. assumes start is a one-cycle pulse given
 when the oscillator is switched on.
*/
`include "ccd_map.svh"

module ccd_stab_timer #(
   parameter int STAB_CYCLES = `CCD_STAB_CYCLES
) (
   // clock and reset
   input  wire logic  clock,
   input  wire logic  srst,
   // control
   input  wire logic  start,
   // status
   output logic       done_q
);

   logic [17:0] cnt_q;
   logic [17:0] cnt_d;
   logic        done_d;

   always_comb
   begin
      cnt_d  = cnt_q;
      done_d = done_q;
      if (start)
      begin
         cnt_d  = 18'(STAB_CYCLES - 1);
         done_d = 1'b0;
      end
      else if (!done_q)
      begin
         if (cnt_q == 18'h0)
            done_d = 1'b1; // RL7
         else
            cnt_d = cnt_q - 18'h1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         cnt_q  <= 18'h0;
         done_q <= 1'b1;
      end
      else
      begin
         cnt_q  <= cnt_d;
         done_q <= done_d;
      end
   end

   a_stab_early : assert property (@(posedge clock) disable iff (srst)
      $rose(done_q) |-> $past(cnt_q) == 18'h0) // RL7
      else $error("stabilization ended before the count ran out");

endmodule

/* File: ccd_top.sv */
/*
 cpu clock divider control: selector register, oscillator run control,
 stabilization wait, standby modes and delayed clock switchover.
 assumes the cpu accesses the register with one-cycle strobes and gives
 stop, halt and wake as one-cycle pulses; the block clock is the oscillator.
*/
`include "ccd_map.svh"

module ccd_top
   import ccd_pkg::*;
#(
   parameter int STAB_CYCLES = `CCD_STAB_CYCLES
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic        rst_pin_n,
   // cpu register access
   input  wire logic [15:0] reg_addr,
   input  wire logic        reg_wr_byte,
   input  wire logic        reg_wr_bit,
   input  wire logic [2:0]  reg_bit_idx,
   input  wire logic        reg_bit_val,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata_q,
   // standby requests from the cpu
   input  wire logic        stop_req,
   input  wire logic        halt_req,
   input  wire logic        wake_req,
   // clock outputs
   output logic             osc_run_q,
   output logic             cpu_run_q,
   output logic             cpu_tick_q,
   output logic             instr_tick_q,
   output logic [3:0]       periph_div_q,
   output ccd_sel_t         active_sel_q
);

   ccd_state_t state_q;
   ccd_state_t state_d;
   ccd_sel_t   reg_sel_q;
   ccd_sel_t   reg_sel_d;
   ccd_sel_t   active_sel_d;
   logic [4:0] sw_cnt_q;
   logic [4:0] sw_cnt_d;
   logic       sw_pend_q;
   logic       sw_pend_d;
   logic       phase_q;
   logic       phase_d;
   logic       instr_tick_d;
   logic       osc_run_d;
   logic       cpu_run_d;
   logic [7:0] reg_rdata_d;
   logic       stab_start;
   logic       stab_done;
   logic       hit;
   logic       rst_all;
   logic [7:0] wr_img;
   logic       wr_any;
   ccd_sel_t   wr_sel;

   // the reset pin resets the register and the standby state like srst
   assign rst_all = srst | ~rst_pin_n;

   ccd_stab_timer #(
      .STAB_CYCLES (STAB_CYCLES)
   ) u_stab (
      .clock  (clock),
      .srst   (srst),
      .start  (stab_start),
      .done_q (stab_done)
   );

   ccd_divider u_div (
      .clock  (clock),
      .srst   (srst),
      .osc_on (osc_run_q),
      .cpu_en (cpu_run_q),
      .sel    (active_sel_q),
      .tick_q (cpu_tick_q),
      .taps_q (periph_div_q)
   );

   // register access
   always_comb
   begin
      hit    = (reg_addr == `CCD_SEL_ADDR);
      wr_img = {5'h00, reg_sel_q};
      if (reg_wr_byte)
         wr_img = reg_wdata; // RL11
      else if (reg_wr_bit)
         wr_img[reg_bit_idx] = reg_bit_val; // RL11
      wr_any = hit & (reg_wr_byte | reg_wr_bit);
      wr_sel = wr_img[`CCD_SEL_MSB:`CCD_SEL_LSB];
      // upper bits are not stored; software keeps them zero
      reg_sel_d = reg_sel_q; // RL3
      if (wr_any && ccd_sel_legal(wr_sel))
         reg_sel_d = wr_sel; // RL14
      reg_rdata_d = 8'h00;
      if (hit && reg_rd)
         reg_rdata_d = {5'h00, reg_sel_q}; // RL14
   end

   always_ff @(posedge clock)
   begin
      if (rst_all)
      begin
         reg_sel_q   <= ccd_sel_t'(`CCD_SEL_RESET); // RL1
         reg_rdata_q <= 8'h00;
      end
      else
      begin
         reg_sel_q   <= reg_sel_d;
         reg_rdata_q <= reg_rdata_d;
      end
   end

   // standby and oscillator control
   always_comb
   begin
      state_d    = state_q;
      stab_start = 1'b0;
      unique case (state_q)
         ST_RESET:
         begin
            state_d    = ST_STAB; // RL7
            stab_start = 1'b1;
         end
         ST_STAB:
            if (stab_done)
               state_d = ST_RUN; // RL7
         ST_RUN:
            if (stop_req)
               state_d = ST_STOP; // RL5
            else if (halt_req)
               state_d = ST_HALT; // RL12
         ST_HALT:
            if (wake_req)
               state_d = ST_RUN; // RL12
         ST_STOP:
            // restart after stop also waits out the stabilization time
            if (wake_req)
            begin
               state_d    = ST_STAB; // RL12
               stab_start = 1'b1;
            end
      endcase
      // an external clock cannot be stopped here; software avoids stop then
      osc_run_d = (state_d != ST_RESET) && (state_d != ST_STOP); // RL5 RL6 RL13
      cpu_run_d = (state_d == ST_RUN);
   end

   always_ff @(posedge clock)
   begin
      if (rst_all)
      begin
         state_q   <= ST_RESET; // RL6
         osc_run_q <= 1'b0; // RL6
         cpu_run_q <= 1'b0;
      end
      else
      begin
         state_q   <= state_d;
         osc_run_q <= osc_run_d;
         cpu_run_q <= cpu_run_d;
      end
   end

   // instruction timing and delayed switchover
   always_comb
   begin
      phase_d      = phase_q;
      instr_tick_d = 1'b0;
      if (cpu_tick_q)
      begin
         phase_d      = ~phase_q;
         instr_tick_d = phase_q; // RL4
      end
      active_sel_d = active_sel_q;
      sw_pend_d    = sw_pend_q;
      sw_cnt_d     = sw_cnt_q;
      if (wr_any && ccd_sel_legal(wr_sel))
      begin
         // a second write restarts the wait from the clock still in effect
         sw_pend_d = 1'b1;
         sw_cnt_d  = ccd_switch_units(active_sel_q); // RL8
      end
      else if (sw_pend_q && instr_tick_q)
      begin
         if (sw_cnt_q <= 5'h01)
         begin
            sw_pend_d    = 1'b0;
            sw_cnt_d     = 5'h00;
            active_sel_d = reg_sel_q; // RL8
         end
         else
            sw_cnt_d = sw_cnt_q - 5'h01; // RL9
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst_all)
      begin
         phase_q      <= 1'b0;
         instr_tick_q <= 1'b0;
         active_sel_q <= ccd_sel_t'(`CCD_SEL_RESET); // RL1
         sw_pend_q    <= 1'b0;
         sw_cnt_q     <= 5'h00;
      end
      else
      begin
         phase_q      <= phase_d;
         instr_tick_q <= instr_tick_d;
         active_sel_q <= active_sel_d;
         sw_pend_q    <= sw_pend_d;
         sw_cnt_q     <= sw_cnt_d;
      end
   end

   a_reset_slowest : assert property (@(posedge clock)
      rst_all |=> (reg_sel_q == 3'h4 && active_sel_q == 3'h4)) // RL1
      else $error("reset did not select divide by sixteen");

   a_illegal_keep : assert property (@(posedge clock) disable iff (rst_all)
      (wr_any && !ccd_sel_legal(wr_sel)) |=> $stable(reg_sel_q)) // RL14
      else $error("prohibited selector code was taken");

   a_read_upper : assert property (@(posedge clock) disable iff (rst_all)
      reg_rdata_q[7:3] == 5'h00) // RL14
      else $error("upper register bits read nonzero");

   a_pin_stops_osc : assert property (@(posedge clock)
      !rst_pin_n |=> !osc_run_q && !cpu_run_q) // RL6
      else $error("oscillator running during pin reset");

   a_stop_halts : assert property (@(posedge clock) disable iff (rst_all)
      (state_q == ST_RUN && stop_req) |=> !osc_run_q && !cpu_run_q) // RL5
      else $error("stop did not halt the oscillator");

   a_halt_keeps : assert property (@(posedge clock) disable iff (rst_all)
      (state_q == ST_HALT) |-> osc_run_q && !cpu_run_q) // RL12
      else $error("halt mode clocks wrong");

   a_stab_hold : assert property (@(posedge clock) disable iff (rst_all)
      $rose(cpu_run_q) && $past(state_q) == ST_STAB |-> $past(stab_done)) // RL7
      else $error("cpu started before stabilization");

   a_instr_two : assert property (@(posedge clock) disable iff (rst_all)
      instr_tick_q |-> $past(cpu_tick_q) && !phase_q) // RL4
      else $error("instruction tick without two cpu clocks");

   a_switch_bound : assert property (@(posedge clock) disable iff (rst_all)
      sw_cnt_q <= ccd_switch_units(active_sel_q)) // RL8 RL9
      else $error("switchover wait beyond old clock limit");

   a_periph_freeze : assert property (@(posedge clock) disable iff (srst)
      !osc_run_q |=> periph_div_q == 4'h0) // RL10
      else $error("peripheral taps move with oscillator stopped");

endmodule

/* File: tb_cpu_clock_divider_control.sv */
/*
 self-checking bench of ccd_top: register reset and access, divider rates,
 switchover delay, standby modes and the stabilization wait.
 assumes ccd_map.svh is on the include path; inputs change at falling edges.
*/
`include "ccd_map.svh"

module tb_cpu_clock_divider_control;
   timeunit 1ns;
   timeprecision 1ps;

   // short wait keeps the run small; every stabilization wait check derives from it
   localparam int STAB  = 16;
   localparam int LIMIT = 20000;

   logic        clock = 1'b0;
   logic        srst, rst_pin_n, reg_wr_byte, reg_wr_bit, reg_bit_val, reg_rd;
   logic        stop_req, halt_req, wake_req;
   logic [15:0] reg_addr;
   logic [2:0]  reg_bit_idx;
   logic [7:0]  reg_wdata, reg_rdata_q;
   logic        osc_run_q, cpu_run_q, cpu_tick_q, instr_tick_q;
   logic [3:0]  periph_div_q;
   logic [2:0]  active_sel_q;
   int          miscompares, total_checks, cycles, seed, model_sel, active, k, a;

   ccd_top #(.STAB_CYCLES(STAB)) DUT (
      .clock(clock), .srst(srst), .rst_pin_n(rst_pin_n),
      .reg_addr(reg_addr), .reg_wr_byte(reg_wr_byte), .reg_wr_bit(reg_wr_bit),
      .reg_bit_idx(reg_bit_idx), .reg_bit_val(reg_bit_val), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .stop_req(stop_req),
      .halt_req(halt_req), .wake_req(wake_req), .osc_run_q(osc_run_q),
      .cpu_run_q(cpu_run_q), .cpu_tick_q(cpu_tick_q), .instr_tick_q(instr_tick_q),
      .periph_div_q(periph_div_q), .active_sel_q(active_sel_q));

   always #2.5 clock = ~clock;

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // model keeps the stored selector; illegal codes leave it alone
   task automatic wr_byte(input logic [15:0] ad, input logic [7:0] d);
      reg_addr = ad;
      reg_wdata = d;
      reg_wr_byte = 1'b1;
      @(negedge clock);
      reg_wr_byte = 1'b0;
      if (ad == `CCD_SEL_ADDR && d[2:0] <= 3'h4) model_sel = d[2:0];
   endtask

   task automatic wr_bit(input logic [2:0] idx, input logic v);
      logic [7:0] img;
      // idle cycle keeps the strobe from being lowered and raised in one step
      @(negedge clock);
      img = 8'(model_sel);
      img[idx] = v;
      reg_addr = `CCD_SEL_ADDR;
      reg_bit_idx = idx;
      reg_bit_val = v;
      reg_wr_bit = 1'b1;
      @(negedge clock);
      reg_wr_bit = 1'b0;
      if (img[2:0] <= 3'h4) model_sel = img[2:0];
   endtask

   task automatic rd(input logic [15:0] ad, input logic [7:0] exp);
      @(negedge clock);
      reg_addr = ad;
      reg_rd = 1'b1;
      @(negedge clock);
      reg_rd = 1'b0;
      check("read data", reg_rdata_q, exp);
   endtask

   task automatic wait_run();
      int n;
      n = 0;
      while (cpu_run_q !== 1'b1 && n < STAB + 8)
      begin
         @(negedge clock);
         n++;
      end
      check("stab wait", 8'(n >= STAB && n <= STAB + 4), 8'h01);
   endtask

   // window of 64 cycles holds a whole number of periods for every code
   task automatic rate(input int sel);
      int c, m;
      c = 0;
      m = 0;
      repeat (64)
      begin
         @(negedge clock);
         c += (cpu_tick_q === 1'b1);
         m += (instr_tick_q === 1'b1);
      end
      check("cpu ticks", 8'(c), 8'(64 >> sel));
      check("instr ticks", 8'(m), 8'(32 >> sel));
   endtask

   task automatic switch_to(input int nxt);
      int n, w;
      n = 0;
      w = 0;
      wr_byte(`CCD_SEL_ADDR, 8'(nxt));
      // the instruction tick standing right after the write already counts
      while (active_sel_q !== 3'(nxt) && w < 2000)
      begin
         if (instr_tick_q === 1'b1) n++;
         @(negedge clock);
         w++;
      end
      check("switch units", 8'(n), 8'(16 >> active));
      check("active sel", 8'(active_sel_q), 8'(nxt));
      active = nxt;
      // the last old-clock tick must leave the rate window
      @(negedge clock);
      rate(nxt);
   endtask

   task automatic pulse(input int which);
      @(negedge clock);
      if (which == 0) stop_req = 1'b1;
      if (which == 1) halt_req = 1'b1;
      if (which == 2) wake_req = 1'b1;
      @(negedge clock);
      {stop_req, halt_req, wake_req} = 3'b000;
   endtask

   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         miscompares++;
         print_verdict();
      end
   end

   initial
   begin
      seed = 32'he09435bf;
      {srst, rst_pin_n, reg_wr_byte, reg_wr_bit, reg_bit_val, reg_rd} = 6'b110000;
      {stop_req, halt_req, wake_req, reg_bit_idx, reg_addr, reg_wdata} = '0;
      repeat (8) @(negedge clock);
      check("osc in reset", 8'(osc_run_q), 8'h00);
      check("sel in reset", 8'(active_sel_q), 8'h04);
      srst = 1'b0;
      model_sel = 4;
      active = 4;
      wait_run();
      rd(`CCD_SEL_ADDR, 8'h04);
      rate(4);
      for (k = 0; k < 11; k++)
         switch_to(k < 5 ? k : (active + 1 + ($unsigned($random(seed)) % 4)) % 5);
      // prohibited codes must not disturb the selector; upper bits stay zero
      for (k = 5; k < 8; k++)
      begin
         wr_byte(`CCD_SEL_ADDR, {5'h00, 3'(k)});
         rd(`CCD_SEL_ADDR, 8'(model_sel));
      end
      if (active != 0) switch_to(0);
      wr_bit(3'h3, 1'b0);
      rd(`CCD_SEL_ADDR, 8'(model_sel));
      wr_bit(3'h2, 1'b1);
      wr_bit(3'h0, 1'b1);
      rd(`CCD_SEL_ADDR, 8'h04);
      repeat (40) @(negedge clock);
      check("bit switch", 8'(active_sel_q), 8'h04);
      active = 4;
      a = $random(seed);
      if (16'(a) == `CCD_SEL_ADDR) a = 0;
      wr_byte(16'(a), 8'h00);
      rd(16'(a), 8'h00);
      rd(`CCD_SEL_ADDR, 8'h04);
      pulse(1);
      check("halt cpu", 8'(cpu_run_q), 8'h00);
      check("halt osc", 8'(osc_run_q), 8'h01);
      pulse(2);
      check("halt wake", 8'(cpu_run_q), 8'h01);
      // no external clock is modelled, so stop is allowed here
      pulse(0);
      check("stop osc", 8'(osc_run_q), 8'h00);
      check("stop cpu", 8'(cpu_run_q), 8'h00);
      repeat (3) @(negedge clock);
      check("periph stop", 8'(periph_div_q), 8'h00);
      check("tick stop", 8'(cpu_tick_q), 8'h00);
      pulse(2);
      check("stop wake", 8'(osc_run_q), 8'h01);
      wait_run();
      switch_to(1);
      rst_pin_n = 1'b0;
      repeat (3) @(negedge clock);
      check("pin osc", 8'(osc_run_q), 8'h00);
      check("pin cpu", 8'(cpu_run_q), 8'h00);
      rst_pin_n = 1'b1;
      model_sel = 4;
      active = 4;
      wait_run();
      rd(`CCD_SEL_ADDR, 8'h04);
      rate(4);
      print_verdict();
   end

endmodule
